// ===== src/flash_scan_arbiter.sv
// program-flash scan arbiter: takes flash cycles from the core to feed the checksum engine
// assumes one instruction clock, core and debugger status synchronous to mclk
`include "flash_scan_arbiter_defs.svh"

// Summary of operation
// RULE1 - burst mode starts at once and suspends the core until the scan ends
// RULE2 - concurrent mode stalls the core only during each scanner flash access
// RULE3 - burst with yield set: interrupt forces scan_run low, burst resumes afterwards
// RULE4 - burst with yield clear: burst continues, interrupt response waits for scan end
// RULE5 - concurrent or triggered with yield set: scanner suspended during interrupt
// RULE6 - concurrent or triggered with yield clear: scanner keeps accessing during interrupt
// RULE7 - peek mode ignores the yield bit
// RULE8 - windowed watchdog keeps running whatever the scanner does
// RULE9 - debug halt freezes scanner; control and start address stay readable
// RULE10 - burst: halt on the setting instruction delays burst; else access finishes first
// RULE11 - external halt during burst suspends it; resumes where stopped at debug exit
// RULE12 - halt just before a scan cycle defers both scan and instruction past debug
// RULE13 - pc breakpoint: pending scan access done before debug entry
// RULE14 - data breakpoint: scan requested in that cycle waits until debug exit
// RULE15 - single step: ready scan access reads flash before debugger re-entry
// RULE16 - scan that would stall a software breakpoint is done first, then debug
// RULE17 - peek lost to debug entry happens after exit when instruction executes
// RULE18 - burst: breakpoint on setting instruction enters debug first, burst runs at exit
// RULE19 - burst: software breakpoint on setting instruction; burst completes at exit
// RULE20 - disable bits switch off checksum and scanner; scanner bit needs fuse
// RULE21 - triggered mode waits for rising edge of selected trigger source
// RULE22 - peek mode uses only cycles where the core leaves flash idle
// RULE23 - end or unimplemented address clears scan_run and sets scan_done_flag
// RULE24 - clearing checksum enable or run aborts scan and sets invalid
// RULE25 - current address steps by one per word from the start address
module flash_scan_arbiter (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [`ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire flash_scan_arbiter_pkg::core_status_s coreStatus,
  input wire flash_scan_arbiter_pkg::debug_event_s debugEvent,
  input wire logic [`TRIGGER_SOURCES-1:0] triggerIn,
  input wire logic scannerFuseAllow,
  input wire logic checksumEnable,
  input wire logic checksumRun,
  input wire logic checksumReady,
  input wire logic unimplementedAddr,
  output flash_scan_arbiter_pkg::flash_grant_s flashGrant,
  output logic intHold,
  output logic scanRunOut,
  output logic scanDoneFlag
);
  import flash_scan_arbiter_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_RUN,
    ST_DEBUG
  } scan_state_e;

  scan_state_e state_q;
  logic [7:0] moduleDisable_q;
  logic scannerOn_q;
  logic scanRun_q;
  logic invalid_q;
  logic interruptYield_q;
  logic [1:0] mode_q;
  flash_addr_t endAddr_q;
  flash_addr_t startAddr_q;
  flash_addr_t curAddr_q;
  logic [3:0] triggerSelect_q;
  logic trigPrev_q;
  logic triggered_q;
  logic scanDone_q;
  logic [7:0] flagsOther_q;
  logic [7:0] enables_q;
  logic [7:0] priorities_q;
  logic pendingScan_q;
  logic debugLate_q;

  logic scannerOff;
  logic active;
  logic trigNow;
  logic trigRise;
  logic isBurst;
  logic isPeek;
  logic yieldNow;
  logic debugEnter;
  logic deferScan;
  logic slotOk;
  logic take;
  logic lastWord;
  logic abort;
  logic ctlWrite;
  logic runSet;
  logic runClear;

  // fuse clear means the scanner cannot be switched off: its disable bit then has no meaning
  assign scannerOff = scannerFuseAllow & moduleDisable_q[`PMD_SCANNER_OFF]; // RULE20
  assign active = scannerOn_q & ~scannerOff & ~moduleDisable_q[`PMD_CHECKSUM_UNIT_OFF]; // RULE20
  assign isBurst = (mode_q == `MODE_BURST);
  assign isPeek = (mode_q == `MODE_PEEK);
  assign trigNow = triggerIn[triggerSelect_q];
  assign trigRise = trigNow & ~trigPrev_q; // RULE21
  // yield only matters outside peek mode
  assign yieldNow = interruptYield_q & ~isPeek & coreStatus.intActive; // RULE3 RULE5 RULE7
  assign debugEnter = debugEvent.extHalt | debugEvent.pcBreak | debugEvent.dataBreak |
    debugEvent.singleStep | debugEvent.swBreak;
  // external halt and data breakpoint push the scan past debug exit; pc, step and sw breakpoints let it finish first
  assign deferScan = debugEvent.extHalt | debugEvent.dataBreak; // RULE12 RULE14
  assign ctlWrite = regWrite & (regAddr == `ADDR_SCAN_CONTROL);
  assign runSet = ctlWrite & regWdata[`CTL_SCAN_RUN] & ~scanRun_q;
  assign runClear = ctlWrite & ~regWdata[`CTL_SCAN_RUN];
  assign abort = scanRun_q & ~(checksumEnable & checksumRun); // RULE24
  assign lastWord = (curAddr_q == endAddr_q) | unimplementedAddr; // RULE23

  always_comb begin
    slotOk = 1'b0;
    if (isPeek) begin
      slotOk = coreStatus.flashIdle; // RULE22
    end else if (isBurst) begin
      slotOk = 1'b1; // RULE1
    end else begin
      slotOk = coreStatus.cycleStart | pendingScan_q; // RULE2
    end
  end

  // a scan access happens only while running, unfrozen, checksum ready and not yielding
  // pc/step/sw breakpoints let the pending access through before debug entry
  assign take = (state_q == ST_RUN) & scanRun_q & active & checksumReady & slotOk &
    ~yieldNow & ~deferScan & ~abort; // RULE4 RULE6 RULE13 RULE15 RULE16

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      triggered_q <= 1'b0;
      debugLate_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          triggered_q <= 1'b0;
          if (scanRun_q && active) begin
            // halt or breakpoint on the setting instruction: burst waits for exit
            if (debugEnter) begin
              state_q <= ST_DEBUG; // RULE10 RULE18 RULE19
            end else if (mode_q == `MODE_TRIGGERED) begin
              state_q <= ST_ARM;
            end else begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_ARM: begin
          if (!scanRun_q || !active) begin
            state_q <= ST_IDLE;
          end else if (debugEnter) begin
            state_q <= ST_DEBUG; // RULE9
          end else if (trigRise) begin
            triggered_q <= 1'b1;
            state_q <= ST_RUN; // RULE21
          end
        end
        ST_RUN: begin
          if (!scanRun_q || !active) begin
            state_q <= ST_IDLE;
          end else if (debugEnter) begin
            // the access granted this cycle completes, then the scanner freezes
            state_q <= ST_DEBUG; // RULE10 RULE11
            debugLate_q <= isPeek & coreStatus.flashIdle & ~take; // RULE17
          end
        end
        ST_DEBUG: begin
          if (debugEvent.resume) begin
            debugLate_q <= 1'b0;
            if (mode_q == `MODE_TRIGGERED && !triggered_q) begin
              state_q <= ST_ARM;
            end else begin
              state_q <= ST_RUN; // RULE11
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // concurrent scan request that was held off by a halt or yield is taken as soon as allowed
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pendingScan_q <= 1'b0;
    end else if (take || !scanRun_q) begin
      pendingScan_q <= 1'b0;
    end else if (!isPeek && !isBurst && coreStatus.cycleStart && state_q == ST_RUN) begin
      pendingScan_q <= 1'b1; // RULE12 RULE14
    end else if (isPeek && debugLate_q && state_q == ST_DEBUG) begin
      pendingScan_q <= 1'b1; // RULE17
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      trigPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= trigNow;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      curAddr_q <= '0;
    end else if (runSet) begin
      curAddr_q <= startAddr_q;
    end else if (take && !lastWord) begin
      curAddr_q <= curAddr_q + `FLASH_ADDR_W'(1); // RULE25
    end
  end

  // scan_run: software sets, hardware clears on end or abort; core writes ignored while bursting
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      scanRun_q <= 1'b0;
      invalid_q <= 1'b0;
    end else begin
      if (abort) begin
        scanRun_q <= 1'b0;
        invalid_q <= 1'b1; // RULE24
      end else if (take && lastWord) begin
        scanRun_q <= 1'b0; // RULE23
      end else if (runSet && checksumEnable && checksumRun) begin
        scanRun_q <= 1'b1;
        invalid_q <= 1'b0;
      end else if (runClear && !(isBurst && state_q == ST_RUN)) begin
        scanRun_q <= 1'b0;
      end
    end
  end

  // done flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      scanDone_q <= 1'b0;
    end else if (take && lastWord) begin
      scanDone_q <= 1'b1; // RULE23
    end else if (regWrite && regAddr == `ADDR_PERIPH_FLAGS_7 &&
                 !regWdata[`PIR_SCAN_DONE_FLAG]) begin
      scanDone_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      moduleDisable_q <= `RESET_BYTE;
      scannerOn_q <= 1'b0;
      interruptYield_q <= 1'b0;
      mode_q <= `MODE_CONCURRENT;
      endAddr_q <= '0;
      startAddr_q <= '0;
      triggerSelect_q <= 4'h0;
      flagsOther_q <= `RESET_BYTE;
      enables_q <= `RESET_BYTE;
      priorities_q <= `RESET_BYTE;
    end else if (regWrite) begin
      if (regAddr == `ADDR_MODULE_DISABLE_0) begin
        moduleDisable_q <= regWdata;
      end else if (regAddr == `ADDR_SCAN_CONTROL) begin
        scannerOn_q <= regWdata[`CTL_SCANNER_ON];
        interruptYield_q <= regWdata[`CTL_INTERRUPT_YIELD];
        mode_q <= regWdata[`CTL_MODE_HI:`CTL_MODE_LO];
      end else if (regAddr == `ADDR_END_UPPER) begin
        endAddr_q[21:16] <= regWdata[5:0];
      end else if (regAddr == `ADDR_END_HIGH) begin
        endAddr_q[15:8] <= regWdata;
      end else if (regAddr == `ADDR_END_LOW) begin
        endAddr_q[7:0] <= regWdata;
      end else if (regAddr == `ADDR_START_UPPER) begin
        startAddr_q[21:16] <= regWdata[5:0];
      end else if (regAddr == `ADDR_START_HIGH) begin
        startAddr_q[15:8] <= regWdata;
      end else if (regAddr == `ADDR_START_LOW) begin
        startAddr_q[7:0] <= regWdata;
      end else if (regAddr == `ADDR_TRIGGER_SELECT) begin
        triggerSelect_q <= regWdata[3:0];
      end else if (regAddr == `ADDR_PERIPH_FLAGS_7) begin
        flagsOther_q <= regWdata & `PIR_WRITE_MASK & 8'h7F;
      end else if (regAddr == `ADDR_PERIPH_ENABLES_7) begin
        enables_q <= regWdata & `PIR_WRITE_MASK;
      end else if (regAddr == `ADDR_PERIPH_PRIORITIES_7) begin
        priorities_q <= regWdata & `PIR_WRITE_MASK;
      end
    end
  end

  // registers stay readable during debug freeze; unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      regRdata <= `RESET_BYTE;
    end else if (regRead) begin
      if (regAddr == `ADDR_MODULE_DISABLE_0) begin
        regRdata <= moduleDisable_q;
      end else if (regAddr == `ADDR_SCAN_CONTROL) begin
        regRdata <= {scannerOn_q, scanRun_q & ~yieldNow, state_q != ST_IDLE, invalid_q,
          interruptYield_q, 1'b0, mode_q}; // RULE9 RULE3 RULE5
      end else if (regAddr == `ADDR_END_UPPER) begin
        regRdata <= {2'h0, endAddr_q[21:16]};
      end else if (regAddr == `ADDR_END_HIGH) begin
        regRdata <= endAddr_q[15:8];
      end else if (regAddr == `ADDR_END_LOW) begin
        regRdata <= endAddr_q[7:0];
      end else if (regAddr == `ADDR_START_UPPER) begin
        regRdata <= {2'h0, startAddr_q[21:16]};
      end else if (regAddr == `ADDR_START_HIGH) begin
        regRdata <= startAddr_q[15:8];
      end else if (regAddr == `ADDR_START_LOW) begin
        regRdata <= startAddr_q[7:0];
      end else if (regAddr == `ADDR_TRIGGER_SELECT) begin
        regRdata <= {4'h0, triggerSelect_q};
      end else if (regAddr == `ADDR_PERIPH_FLAGS_7) begin
        regRdata <= {scanDone_q, flagsOther_q[6:0]};
      end else if (regAddr == `ADDR_PERIPH_ENABLES_7) begin
        regRdata <= enables_q;
      end else if (regAddr == `ADDR_PERIPH_PRIORITIES_7) begin
        regRdata <= priorities_q;
      end else if (regAddr == `ADDR_CURRENT_UPPER) begin
        regRdata <= {2'h0, curAddr_q[21:16]};
      end else if (regAddr == `ADDR_CURRENT_HIGH) begin
        regRdata <= curAddr_q[15:8];
      end else if (regAddr == `ADDR_CURRENT_LOW) begin
        regRdata <= curAddr_q[7:0];
      end else begin
        regRdata <= `RESET_BYTE;
      end
    end else begin
      regRdata <= `RESET_BYTE;
    end
  end

  // outputs registered; no watchdog gating exists here on purpose, so long bursts can trip it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      flashGrant <= '0;
      intHold <= 1'b0;
      scanRunOut <= 1'b0;
      scanDoneFlag <= 1'b0;
    end else begin
      flashGrant.scanAccess <= take;
      flashGrant.addr <= curAddr_q;
      // burst holds the core for the whole scan unless an interrupt yields; peek never stalls
      flashGrant.coreStall <= (isBurst & scanRun_q & (state_q == ST_RUN) & ~yieldNow) |
        (take & ~isPeek); // RULE1 RULE2 RULE3 RULE8
      intHold <= isBurst & scanRun_q & ~interruptYield_q & (state_q != ST_IDLE); // RULE4
      scanRunOut <= scanRun_q & ~yieldNow;
      scanDoneFlag <= scanDone_q;
    end
  end

endmodule // flash_scan_arbiter

// ===== src/flash_scan_arbiter_defs.svh
// constants for the program-flash scan arbiter: register offsets, fields, reset values
// assumes inclusion by bare name from the package and the design module
`ifndef FLASH_SCAN_ARBITER_DEFS_SVH
`define FLASH_SCAN_ARBITER_DEFS_SVH

`define ADDR_W 4
`define ADDR_MODULE_DISABLE_0 4'h0
`define ADDR_SCAN_CONTROL 4'h1
`define ADDR_END_UPPER 4'h2
`define ADDR_END_HIGH 4'h3
`define ADDR_END_LOW 4'h4
`define ADDR_START_UPPER 4'h5
`define ADDR_START_HIGH 4'h6
`define ADDR_START_LOW 4'h7
`define ADDR_TRIGGER_SELECT 4'h8
`define ADDR_PERIPH_FLAGS_7 4'h9
`define ADDR_PERIPH_ENABLES_7 4'hA
`define ADDR_PERIPH_PRIORITIES_7 4'hB
`define ADDR_CURRENT_UPPER 4'hC
`define ADDR_CURRENT_HIGH 4'hD
`define ADDR_CURRENT_LOW 4'hE

// scanner_control fields
`define CTL_SCANNER_ON 7
`define CTL_SCAN_RUN 6
`define CTL_BUSY 5
`define CTL_INVALID 4
`define CTL_INTERRUPT_YIELD 3
`define CTL_MODE_HI 1
`define CTL_MODE_LO 0
`define CTL_WRITE_MASK 8'hCB

// module_disable_0 fields
`define PMD_CHECKSUM_UNIT_OFF 4
`define PMD_SCANNER_OFF 3

// peripheral_flags_7 fields
`define PIR_SCAN_DONE_FLAG 7
`define PIR_WRITE_MASK 8'hE1

`define MODE_CONCURRENT 2'h0
`define MODE_BURST 2'h1
`define MODE_PEEK 2'h2
`define MODE_TRIGGERED 2'h3

`define FLASH_ADDR_W 22
`define RESET_BYTE 8'h00
`define TRIGGER_SOURCES 16

`endif

// ===== src/flash_scan_arbiter_pkg.sv
// types shared by the program-flash scan arbiter and its bench
// assumes the defs header is on the include path
`include "flash_scan_arbiter_defs.svh"

package flash_scan_arbiter_pkg;

  typedef logic [`FLASH_ADDR_W-1:0] flash_addr_t;

  typedef enum logic [1:0] {
    SCAN_CONCURRENT,
    SCAN_BURST,
    SCAN_PEEK,
    SCAN_TRIGGERED
  } scan_mode_e;

  // status of the core as seen by the arbiter, one instruction cycle at a time
  typedef struct packed {
    logic cycleStart;
    logic flashIdle;
    logic setsScanRun;
    logic intActive;
  } core_status_s;

  // debugger events
  typedef struct packed {
    logic extHalt;
    logic pcBreak;
    logic dataBreak;
    logic singleStep;
    logic swBreak;
    logic resume;
  } debug_event_s;

  // flash access handed out by the arbiter
  typedef struct packed {
    logic scanAccess;
    logic coreStall;
    flash_addr_t addr;
  } flash_grant_s;

endpackage

// ===== tb/flash_scan_arbiter_props.sv
// checker for the flash scan arbiter, bound to the ports of its top module
// assumes the package and the defs header are compiled before it
`include "flash_scan_arbiter_defs.svh"

module flash_scan_arbiter_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [`ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire flash_scan_arbiter_pkg::core_status_s coreStatus,
  input wire flash_scan_arbiter_pkg::debug_event_s debugEvent,
  input wire logic [`TRIGGER_SOURCES-1:0] triggerIn,
  input wire logic scannerFuseAllow,
  input wire logic checksumEnable,
  input wire logic checksumRun,
  input wire logic checksumReady,
  input wire logic unimplementedAddr,
  input wire flash_scan_arbiter_pkg::flash_grant_s flashGrant,
  input wire logic intHold,
  input wire logic scanRunOut,
  input wire logic scanDoneFlag
);
  timeunit 1ns;
  timeprecision 1ns;
  import flash_scan_arbiter_pkg::*;
  logic [1:0] modeQ;
  logic yieldQ;
  logic offQ;
  logic frozenQ;
  logic yieldNow;
  // mirror of the control fields, since the checker cannot see the register file
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      modeQ <= 2'h0;
      yieldQ <= 1'b0;
    end else if (regWrite && regAddr == `ADDR_SCAN_CONTROL) begin
      modeQ <= regWdata[`CTL_MODE_HI:`CTL_MODE_LO];
      yieldQ <= regWdata[`CTL_INTERRUPT_YIELD];
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) offQ <= 1'b0;
    else if (regWrite && regAddr == `ADDR_MODULE_DISABLE_0) offQ <= regWdata[`PMD_SCANNER_OFF];
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) frozenQ <= 1'b0;
    else if (debugEvent.resume) frozenQ <= 1'b0;
    else if (debugEvent.extHalt || debugEvent.dataBreak) frozenQ <= 1'b1;
  end
  assign yieldNow = coreStatus.intActive && yieldQ && modeQ != `MODE_PEEK;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside its slot");
  chk_access_stalls: assert property (
    flashGrant.scanAccess && modeQ != `MODE_PEEK |-> flashGrant.coreStall)
    else $error("scan access without core stall");
  chk_peek_no_stall: assert property (modeQ == `MODE_PEEK |-> !flashGrant.coreStall)
    else $error("core stalled in peek mode");
  chk_peek_dead_slot: assert property (
    flashGrant.scanAccess && modeQ == `MODE_PEEK |-> $past(coreStatus.flashIdle))
    else $error("peek access in a busy core cycle");
  chk_yield_pause: assert property (yieldNow |=> !flashGrant.scanAccess)
    else $error("scan access during yielded interrupt");
  chk_hold_burst: assert property (intHold |-> modeQ == `MODE_BURST && !yieldQ)
    else $error("interrupt held outside burst without yield");
  chk_halt_refuse: assert property (
    debugEvent.extHalt || debugEvent.dataBreak |=> !flashGrant.scanAccess)
    else $error("access taken in halt cycle");
  chk_frozen_still: assert property (frozenQ && !debugEvent.resume |=> !flashGrant.scanAccess)
    else $error("access while frozen in debug");
  chk_ready_gate: assert property (!checksumReady |=> !flashGrant.scanAccess)
    else $error("access while engine not ready");
  chk_off_refuse: assert property (offQ && scannerFuseAllow |=> !flashGrant.scanAccess)
    else $error("access while scanner disabled");
  chk_addr_step: assert property (
    flashGrant.scanAccess && $past(flashGrant.scanAccess)
      |-> flashGrant.addr == $past(flashGrant.addr) + 22'h1)
    else $error("address did not step by one");
  chk_done_ends_run: assert property ($rose(scanDoneFlag) |-> ##[0:2] !scanRunOut)
    else $error("done flag with scan still running");
endmodule // flash_scan_arbiter_props

bind flash_scan_arbiter flash_scan_arbiter_props chk (
  .mclk(mclk),
  .reset_n(reset_n),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regWrite(regWrite),
  .regRead(regRead),
  .regRdata(regRdata),
  .coreStatus(coreStatus),
  .debugEvent(debugEvent),
  .triggerIn(triggerIn),
  .scannerFuseAllow(scannerFuseAllow),
  .checksumEnable(checksumEnable),
  .checksumRun(checksumRun),
  .checksumReady(checksumReady),
  .unimplementedAddr(unimplementedAddr),
  .flashGrant(flashGrant),
  .intHold(intHold),
  .scanRunOut(scanRunOut),
  .scanDoneFlag(scanDoneFlag)
);

// ===== tb/scan_partner_model.sv
// model of the core and checksum engine sharing program flash with the scanner
// assumes mclk is the instruction clock; the bench steers interrupts and engine state
module scan_partner_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic intReq,
  input wire logic intHold,
  input wire logic csOn,
  input wire logic slow,
  output flash_scan_arbiter_pkg::core_status_s coreStatus,
  output logic checksumEnable,
  output logic checksumRun,
  output logic checksumReady
);
  timeunit 1ns;
  timeprecision 1ns;
  import flash_scan_arbiter_pkg::*;
  logic [1:0] phaseQ;
  always_ff @(posedge mclk) begin
    if (!reset_n) phaseQ <= 2'h0;
    else phaseQ <= phaseQ + 2'h1;
  end
  // the core fetches in three cycles of four; the fourth is a dead slot for peeks
  // an interrupt the arbiter holds off is not entered
  assign coreStatus = {phaseQ == 2'h0, phaseQ == 2'h3, 1'b0, intReq && !intHold};
  assign checksumEnable = csOn;
  assign checksumRun = csOn;
  // a slow engine takes a word only every other cycle
  assign checksumReady = !slow || phaseQ[0];
endmodule // scan_partner_model

// ===== tb/test_flash_scan_arbiter.sv
// bench for the flash scan arbiter: registers, modes, interrupts, debug, gating, abort
// assumes package, checker and partner model are compiled before it
`include "flash_scan_arbiter_defs.svh"

module test_flash_scan_arbiter;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_scan_arbiter_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  core_status_s coreStatus;
  debug_event_s dbg = '0;
  logic [15:0] triggerIn = 16'h0000;
  logic fuse = 1'b1;
  logic csOn = 1'b1;
  logic intReq = 1'b0;
  logic slow = 1'b0;
  logic unimpl = 1'b0;
  logic csEnable;
  logic csRun;
  logic csReady;
  flash_grant_s flashGrant;
  logic intHold;
  logic scanRunOut;
  logic scanDoneFlag;
  flash_addr_t expAddr = '0;
  int nAcc = 0;
  int n_mismatch = 0;
  int check_count = 0;

  always #10 mclk = ~mclk;

  flash_scan_arbiter uut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .coreStatus(coreStatus), .debugEvent(dbg), .triggerIn(triggerIn),
    .scannerFuseAllow(fuse), .checksumEnable(csEnable), .checksumRun(csRun),
    .checksumReady(csReady), .unimplementedAddr(unimpl), .flashGrant(flashGrant),
    .intHold(intHold), .scanRunOut(scanRunOut), .scanDoneFlag(scanDoneFlag));

  scan_partner_model pm (.mclk(mclk), .reset_n(reset_n), .intReq(intReq), .intHold(intHold),
    .csOn(csOn), .slow(slow), .coreStatus(coreStatus), .checksumEnable(csEnable),
    .checksumRun(csRun), .checksumReady(csReady));

  task automatic cmp(input logic [21:0] got, input logic [21:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    // data launched at the previous edge still stands here, before this edge's update
    @(posedge mclk);
    cmp(22'(regRdata), 22'(exp));
  endtask

  // every word handed out must follow the previous one
  always @(posedge mclk) begin
    if (flashGrant.scanAccess === 1'b1) begin
      cmp(flashGrant.addr, expAddr);
      expAddr <= expAddr + 22'h1;
      nAcc <= nAcc + 1;
    end
  end

  task automatic go(input logic [7:0] ctl, input logic [7:0] s, input logic [7:0] e);
    wr(`ADDR_START_LOW, s);
    wr(`ADDR_END_LOW, e);
    expAddr = 22'(s);
    nAcc = 0;
    wr(`ADDR_SCAN_CONTROL, ctl);
  endtask

  task automatic finish(input logic [7:0] ctl, input int n);
    for (int i = 0; i < 400 && scanDoneFlag !== 1'b1; i++) @(posedge mclk);
    repeat (3) @(posedge mclk);
    cmp(22'(nAcc), 22'(n));
    rd(`ADDR_SCAN_CONTROL, ctl & 8'hBF);
    rd(`ADDR_PERIPH_FLAGS_7, 8'h80);
    wr(`ADDR_PERIPH_FLAGS_7, 8'h00);
  endtask

  task automatic t_regs();
    for (int a = 0; a < 16; a++) rd(4'(a), `RESET_BYTE);
    wr(`ADDR_PERIPH_ENABLES_7, 8'hA5);
    rd(`ADDR_PERIPH_ENABLES_7, 8'hA1);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    csOn <= 1'b0;
    wr(`ADDR_SCAN_CONTROL, 8'hFF);
    rd(`ADDR_SCAN_CONTROL, 8'h8B);
    wr(`ADDR_SCAN_CONTROL, 8'h00);
    csOn <= 1'b1;
  endtask

  task automatic t_yield(input logic [7:0] ctl, input logic stop);
    intReq <= 1'b1;
    go(ctl, 8'h10, 8'h13);
    repeat (3) @(posedge mclk);
    cmp(22'(intHold), 22'(ctl == 8'hC1));
    repeat (17) @(posedge mclk);
    cmp(22'(nAcc == 0), 22'(stop));
    if (stop) cmp(22'(scanRunOut), 22'h0);
    intReq <= 1'b0;
    finish(ctl, 4);
  endtask

  task automatic t_halt(input logic [7:0] ctl, input logic [5:0] ev, input logic frz);
    int n;
    go(ctl, 8'h20, 8'h3F);
    for (int i = 0; i < 200 && nAcc < 3; i++) @(posedge mclk);
    dbg <= debug_event_s'(ev);
    @(posedge mclk);
    dbg <= '0;
    repeat (2) @(posedge mclk);
    n = nAcc;
    repeat (10) @(posedge mclk);
    if (frz) cmp(22'(nAcc), 22'(n));
    dbg <= debug_event_s'(6'h01);
    @(posedge mclk);
    dbg <= '0;
    finish(ctl, 32);
  endtask

  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    go(8'hC0, 8'h10, 8'h13);
    finish(8'hC0, 4);
    go(8'hC1, 8'h10, 8'h13);
    finish(8'hC1, 4);
    go(8'hC2, 8'h10, 8'h13);
    finish(8'hC2, 4);
    wr(`ADDR_TRIGGER_SELECT, 8'h05);
    go(8'hC3, 8'h10, 8'h13);
    triggerIn <= 16'h0010;
    repeat (20) @(posedge mclk);
    cmp(22'(nAcc), 22'h0);
    triggerIn <= 16'h0020;
    finish(8'hC3, 4);
    triggerIn <= 16'h0000;
    t_yield(8'hC9, 1'b1);
    t_yield(8'hC1, 1'b0);
    t_yield(8'hC8, 1'b1);
    t_yield(8'hC0, 1'b0);
    t_yield(8'hCA, 1'b0);
    slow <= 1'b1;
    t_halt(8'hC1, 6'h20, 1'b1);
    slow <= 1'b0;
    t_halt(8'hC0, 6'h20, 1'b1);
    t_halt(8'hC0, 6'h08, 1'b1);
    t_halt(8'hC0, 6'h10, 1'b0);
    t_halt(8'hC0, 6'h04, 1'b0);
    t_halt(8'hC0, 6'h02, 1'b0);
    t_halt(8'hC2, 6'h20, 1'b1);
    fuse <= 1'b0;
    wr(`ADDR_MODULE_DISABLE_0, 8'h08);
    go(8'hC0, 8'h10, 8'h13);
    finish(8'hC0, 4);
    fuse <= 1'b1;
    go(8'hC0, 8'h10, 8'h13);
    repeat (20) @(posedge mclk);
    cmp(22'(nAcc), 22'h0);
    wr(`ADDR_SCAN_CONTROL, 8'h00);
    wr(`ADDR_MODULE_DISABLE_0, 8'h00);
    // an unimplemented address ends the scan at the next word, like the end address
    go(8'hC0, 8'h50, 8'h7F);
    for (int i = 0; i < 200 && nAcc < 2; i++) @(posedge mclk);
    unimpl <= 1'b1;
    finish(8'hC0, 3);
    unimpl <= 1'b0;
    go(8'hC0, 8'h40, 8'h7F);
    for (int i = 0; i < 200 && nAcc < 2; i++) @(posedge mclk);
    csOn <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(`ADDR_SCAN_CONTROL, 8'h90);
    csOn <= 1'b1;
    wrap_up();
  end
endmodule // test_flash_scan_arbiter
